// ### design/sssp_defines.svh
`ifndef SSSP_DEFINES_SVH
`define SSSP_DEFINES_SVH

// Register byte offsets on the APB side
`define SSSP_OFS_RX_CTL 8'h00
`define SSSP_OFS_TX_HOLD 8'h04
`define SSSP_OFS_TX_CTL 8'h08
`define SSSP_OFS_BAUD_CTL 8'h0C
`define SSSP_OFS_DIV_HI 8'h10
`define SSSP_OFS_DIV_LO 8'h14
`define SSSP_OFS_RX_HOLD 8'h18
`define SSSP_OFS_IRQ_STAT 8'h1C
`define SSSP_OFS_IRQ_CLR 8'h20
`define SSSP_OFS_IRQ_EN 8'h24
`define SSSP_OFS_INT_CTL 8'h28
`define SSSP_OFS_FLAGS 8'h2C

// Writable bits of each register
`define SSSP_MASK_RX_CTL 8'hF8
`define SSSP_MASK_TX_CTL 8'hFD
`define SSSP_MASK_BAUD_CTL 8'h3B
`define SSSP_MASK_IRQ 8'h07
`define SSSP_MASK_INT_CTL 8'hC0

// Field positions, receive status/control
`define SSSP_B_PORT_EN 7
`define SSSP_B_RX_NINTH_EN 6
`define SSSP_B_CONT_RX 4
`define SSSP_B_OVERRUN 1
`define SSSP_B_RX_NINTH_VAL 0
// Transmit status/control
`define SSSP_B_CLK_SRC 7
`define SSSP_B_TX_NINTH_EN 6
`define SSSP_B_TX_EN 5
`define SSSP_B_SYNC_MODE 4
`define SSSP_B_TX_EMPTY 1
`define SSSP_B_TX_NINTH_VAL 0
// Baud control
`define SSSP_B_RX_IDLE 6
`define SSSP_B_POL_INV 4
// Interrupt control
`define SSSP_B_GLOBAL_IE 7
`define SSSP_B_PERIPH_IE 6
// Interrupt status, clear and enable
`define SSSP_B_IRQ_TX 0
`define SSSP_B_IRQ_RX 1
`define SSSP_B_IRQ_OVR 2

// Reset values
`define SSSP_RST_BYTE 8'h00
`define SSSP_RST_WORD 32'h00000000

`endif

// ### design/sssp_pkg.sv
`default_nettype none

package sssp_pkg;

	typedef logic [7:0] sssp_addr_t;
	typedef logic [31:0] sssp_word_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} sssp_tx_state_t;

endpackage

`default_nettype wire

// ### design/sssp_port.sv
// Functional notes
// RULE1 - Under sleep, first queued word moves into the shift register and sends
// RULE2 - Second word waits in holding register; free flag stays clear meanwhile
// RULE3 - After first word shifts out, second loads, then free flag sets
// RULE4 - Free flag with transmit interrupt enabled raises interrupt and wake
// RULE5 - Software selects slave: clocked mode and port enable set, source clear
// RULE6 - Polarity invert bit inverts the sensed shift strobe pin
// RULE7 - Ninth-bit enable sends nine bits, ninth from the ninth-bit value
// RULE8 - With transmit enabled, holding register write starts slave transmission
// RULE9 - Software clears both receive enables before a slave transmission
// RULE10 - Single receive enable ignored; continuous enable alone controls reception
// RULE11 - Continuous reception keeps working in sleep or idle
// RULE12 - Received word copied to holding register; enabled interrupt wakes device
// RULE13 - Receive done flag sets on completion, interrupt if enabled
// RULE14 - Receive ninth-bit enable gives nine bits; ninth and error readable
// RULE15 - Receive holding read returns low eight data bits
// RULE16 - Clearing continuous receive enable clears pending overrun error
// RULE17 - Software sets global and peripheral enables, bits 7 and 6
// RULE18 - External master supplies the shift strobe in slave mode
// RULE19 - One bit per strobe cycle; strobe synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "sssp_defines.svh"

module sssp_port (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire sssp_pkg::sssp_addr_t paddr,
	input wire sssp_pkg::sssp_word_t pwdata,
	output sssp_pkg::sssp_word_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shift_strobe_pin,
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe,
	input wire logic cpu_sleep,
	output logic irq,
	output logic cpu_irq,
	output logic wake_req
);
	import sssp_pkg::*;

	function automatic logic [3:0] word_bits(input logic ninth);
		word_bits = ninth ? 4'h9 : 4'h8;
	endfunction

	logic [7:0] rx_ctl;
	logic [7:0] tx_ctl;
	logic [7:0] baud_ctl;
	logic [7:0] baud_divisor_high;
	logic [7:0] baud_divisor_low;
	logic [7:0] irq_enable;
	logic [7:0] interrupt_control_reg;
	logic [7:0] transmit_holding_reg;
	logic [7:0] receive_holding_reg;
	logic [8:0] transmit_shift_reg;
	logic [8:0] receive_shift_reg;
	logic [8:0] next_rx_shift;
	logic [3:0] tx_cnt;
	logic [3:0] rx_cnt;
	logic hold_full;
	logic receive_done_flag;
	logic overrun;
	logic rx_ninth;
	sssp_tx_state_t tx_state;
	logic strobe_q1;
	logic strobe_q2;
	logic strobe_prev;
	logic data_q1;
	logic data_q2;
	logic strobe_eff;
	logic strobe_rise;
	logic strobe_fall;
	logic [2:0] irq_stat;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	logic bus_wr;
	logic bus_rd;
	logic setup;
	logic hold_wr;
	logic rx_hold_rd;
	logic serial_port_enable;
	logic slave_mode;
	logic transmit_enable;
	logic continuous_receive_enable;
	logic clock_polarity_invert;
	logic tx_ninth_bit_enable;
	logic rx_ninth_bit_enable;
	logic tx_go;
	logic rx_en;
	logic tx_load;
	logic rx_done;
	logic rx_accept;
	logic rx_overrun;
	logic transmit_buffer_free_flag;
	logic [7:0] rd_rx_ctl;
	logic [7:0] rd_tx_ctl;
	logic [7:0] rd_baud;

	assign setup = psel & ~penable;
	assign bus_wr = psel & penable & pwrite;
	assign bus_rd = psel & penable & ~pwrite;
	assign pready = psel & penable;
	assign hold_wr = bus_wr && paddr == `SSSP_OFS_TX_HOLD;
	assign rx_hold_rd = bus_rd && paddr == `SSSP_OFS_RX_HOLD;

	assign serial_port_enable = rx_ctl[`SSSP_B_PORT_EN];
	assign continuous_receive_enable = rx_ctl[`SSSP_B_CONT_RX];
	assign rx_ninth_bit_enable = rx_ctl[`SSSP_B_RX_NINTH_EN];
	assign transmit_enable = tx_ctl[`SSSP_B_TX_EN];
	assign tx_ninth_bit_enable = tx_ctl[`SSSP_B_TX_NINTH_EN];
	assign clock_polarity_invert = baud_ctl[`SSSP_B_POL_INV];
	// Only the clocked, externally strobed mode moves data here
	assign slave_mode = serial_port_enable & tx_ctl[`SSSP_B_SYNC_MODE]
		& ~tx_ctl[`SSSP_B_CLK_SRC]; // see RULE5
	assign tx_go = slave_mode & transmit_enable; // see RULE8
	// The single receive bit is stored but never looked at
	assign rx_en = slave_mode & continuous_receive_enable & ~overrun
		& (tx_state == TX_IDLE); // see RULE10 see RULE9
	assign transmit_buffer_free_flag = ~hold_full;

	// Register writes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_ctl <= `SSSP_RST_BYTE;
			tx_ctl <= `SSSP_RST_BYTE;
			baud_ctl <= `SSSP_RST_BYTE;
			baud_divisor_high <= `SSSP_RST_BYTE;
			baud_divisor_low <= `SSSP_RST_BYTE;
			irq_enable <= `SSSP_RST_BYTE;
			interrupt_control_reg <= `SSSP_RST_BYTE;
		end else if (bus_wr) begin
			case (paddr)
			`SSSP_OFS_RX_CTL: rx_ctl <= pwdata[7:0] & `SSSP_MASK_RX_CTL;
			`SSSP_OFS_TX_CTL: tx_ctl <= pwdata[7:0] & `SSSP_MASK_TX_CTL;
			`SSSP_OFS_BAUD_CTL: baud_ctl <= pwdata[7:0] & `SSSP_MASK_BAUD_CTL;
			`SSSP_OFS_DIV_HI: baud_divisor_high <= pwdata[7:0];
			`SSSP_OFS_DIV_LO: baud_divisor_low <= pwdata[7:0];
			`SSSP_OFS_IRQ_EN: irq_enable <= pwdata[7:0] & `SSSP_MASK_IRQ;
			`SSSP_OFS_INT_CTL: begin
				interrupt_control_reg <= pwdata[7:0] & `SSSP_MASK_INT_CTL;
			end
			default: ;
			endcase
		end
	end

	// Strobe and data pins come from the master's domain
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			strobe_q1 <= 1'b0;
			strobe_q2 <= 1'b0;
			data_q1 <= 1'b0;
			data_q2 <= 1'b0;
		end else begin
			strobe_q1 <= shift_strobe_pin; // see RULE19
			strobe_q2 <= strobe_q1;
			data_q1 <= data_pin_in;
			data_q2 <= data_q1;
		end
	end

	assign strobe_eff = strobe_q2 ^ clock_polarity_invert; // see RULE6

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= strobe_eff;
		end
	end

	// Flipping the polarity bit mid-word fakes an edge; change it idle only
	assign strobe_rise = strobe_eff & ~strobe_prev;
	assign strobe_fall = ~strobe_eff & strobe_prev;

	// Holding register: loaded by software, emptied into the shifter
	assign tx_load = tx_go & hold_full & (tx_state == TX_IDLE); // see RULE1

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			transmit_holding_reg <= `SSSP_RST_BYTE;
			hold_full <= 1'b0;
		end else if (hold_wr) begin
			transmit_holding_reg <= pwdata[7:0];
			hold_full <= 1'b1;
		end else if (tx_load) begin
			hold_full <= 1'b0; // see RULE3
		end
	end

	// Shifter: a bit goes out on each rising strobe, ends on the last fall
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_state <= TX_IDLE;
			transmit_shift_reg <= 9'h000;
			tx_cnt <= 4'h0;
			data_pin_out <= 1'b0;
		end else if (!tx_go) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 4'h0;
		end else begin
			case (tx_state)
			TX_IDLE: begin
				if (hold_full) begin
					transmit_shift_reg <= {tx_ctl[`SSSP_B_TX_NINTH_VAL]
						& tx_ninth_bit_enable,
						transmit_holding_reg}; // see RULE7
					tx_cnt <= 4'h0;
					tx_state <= TX_SHIFT; // see RULE8
				end
			end
			TX_SHIFT: begin
				// The waiting word stays put until this one is gone
				if (strobe_rise && tx_cnt != word_bits(tx_ninth_bit_enable)) begin
					data_pin_out <= transmit_shift_reg[0]; // see RULE19
					transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
					tx_cnt <= tx_cnt + 4'h1;
				end else if (strobe_fall
					&& tx_cnt == word_bits(tx_ninth_bit_enable)) begin
					tx_state <= TX_IDLE; // see RULE2
				end
			end
			default: tx_state <= TX_IDLE;
			endcase
		end
	end

	assign data_pin_oe = (tx_state == TX_SHIFT);

	// Receiver samples on falling strobe; runs regardless of cpu_sleep
	always_comb begin
		next_rx_shift = receive_shift_reg;
		next_rx_shift[rx_cnt] = data_q2;
	end

	assign rx_done = rx_en & strobe_fall
		& (rx_cnt == word_bits(rx_ninth_bit_enable) - 4'h1); // see RULE11
	// A read in the same cycle frees the holding register in time
	assign rx_accept = rx_done & (~receive_done_flag | rx_hold_rd);
	assign rx_overrun = rx_done & receive_done_flag & ~rx_hold_rd;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			receive_shift_reg <= 9'h000;
			rx_cnt <= 4'h0;
		end else if (!rx_en) begin
			rx_cnt <= 4'h0;
		end else if (strobe_fall) begin
			receive_shift_reg <= next_rx_shift;
			rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
		end
	end

	// Only one word of receive storage: a second word before a read is lost
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			receive_holding_reg <= `SSSP_RST_BYTE;
			rx_ninth <= 1'b0;
			receive_done_flag <= 1'b0;
		end else if (rx_accept) begin
			receive_holding_reg <= next_rx_shift[7:0]; // see RULE12
			rx_ninth <= rx_ninth_bit_enable & next_rx_shift[8]; // see RULE14
			receive_done_flag <= 1'b1; // see RULE13
		end else if (rx_hold_rd) begin
			receive_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			overrun <= 1'b0;
		end else if (!continuous_receive_enable) begin
			overrun <= 1'b0; // see RULE16
		end else if (rx_overrun) begin
			overrun <= 1'b1;
		end
	end

	// Sticky event bits; a new event beats a clear in the same cycle
	assign irq_ev[`SSSP_B_IRQ_TX] = tx_load;
	assign irq_ev[`SSSP_B_IRQ_RX] = rx_accept;
	assign irq_ev[`SSSP_B_IRQ_OVR] = rx_overrun;
	assign irq_clr = (bus_wr && paddr == `SSSP_OFS_IRQ_CLR) ?
		pwdata[2:0] : 3'h0;

	for (genvar gi = 0; gi < 3; gi++) begin : g_sticky
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				irq_stat[gi] <= 1'b0;
			end else if (irq_ev[gi]) begin
				irq_stat[gi] <= 1'b1;
			end else if (irq_clr[gi]) begin
				irq_stat[gi] <= 1'b0;
			end
		end
	end

	assign irq = |(irq_stat & irq_enable[2:0]); // see RULE4 see RULE13
	// Wake needs no global enable; vectoring to the core does
	assign wake_req = irq & cpu_sleep; // see RULE12
	assign cpu_irq = irq & interrupt_control_reg[`SSSP_B_GLOBAL_IE]
		& interrupt_control_reg[`SSSP_B_PERIPH_IE]; // see RULE17

	always_comb begin
		rd_rx_ctl = rx_ctl;
		rd_rx_ctl[`SSSP_B_OVERRUN] = overrun; // see RULE14
		rd_rx_ctl[`SSSP_B_RX_NINTH_VAL] = rx_ninth;
		rd_tx_ctl = tx_ctl;
		rd_tx_ctl[`SSSP_B_TX_EMPTY] = (tx_state == TX_IDLE);
		rd_baud = baud_ctl;
		rd_baud[`SSSP_B_RX_IDLE] = (rx_cnt == 4'h0);
	end

	// Read data is captured in the setup cycle, so no wait states
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= `SSSP_RST_WORD;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= 1'b0;
			prdata <= `SSSP_RST_WORD;
			case (paddr)
			`SSSP_OFS_RX_CTL: prdata[7:0] <= rd_rx_ctl;
			`SSSP_OFS_TX_HOLD: ;
			`SSSP_OFS_TX_CTL: prdata[7:0] <= rd_tx_ctl;
			`SSSP_OFS_BAUD_CTL: prdata[7:0] <= rd_baud;
			`SSSP_OFS_DIV_HI: prdata[7:0] <= baud_divisor_high;
			`SSSP_OFS_DIV_LO: prdata[7:0] <= baud_divisor_low;
			`SSSP_OFS_RX_HOLD: prdata[7:0] <= receive_holding_reg; // see RULE15
			`SSSP_OFS_IRQ_STAT: prdata[2:0] <= irq_stat;
			`SSSP_OFS_IRQ_CLR: ;
			`SSSP_OFS_IRQ_EN: prdata[7:0] <= irq_enable;
			`SSSP_OFS_INT_CTL: prdata[7:0] <= interrupt_control_reg;
			`SSSP_OFS_FLAGS: begin
				prdata[1:0] <= {receive_done_flag, transmit_buffer_free_flag};
			end
			default: pslverr <= 1'b1;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	property p_tx_load;
		tx_load && !hold_wr |=> tx_state == TX_SHIFT && !hold_full;
	endproperty
	a_tx_load: assert property (p_tx_load) // see RULE1
		else $error("queued word did not enter the shifter");

	property p_hold_waits;
		tx_state == TX_SHIFT && hold_full |=> hold_full;
	endproperty
	a_hold_waits: assert property (p_hold_waits) // see RULE2
		else $error("holding register emptied while shifting");

	property p_tx_irq;
		irq_stat[`SSSP_B_IRQ_TX] && irq_enable[`SSSP_B_IRQ_TX] && cpu_sleep
			|-> irq && wake_req;
	endproperty
	a_tx_irq: assert property (p_tx_irq) // see RULE4
		else $error("transmit event did not wake");

	property p_edge_shift;
		tx_state == TX_SHIFT && $past(tx_state) == TX_SHIFT
			&& $changed(transmit_shift_reg) |-> $past(strobe_rise);
	endproperty
	a_edge_shift: assert property (p_edge_shift) // see RULE6
		else $error("bit shifted without a strobe edge");

	property p_ninth;
		tx_load && tx_ninth_bit_enable
			|=> transmit_shift_reg[8] == $past(tx_ctl[`SSSP_B_TX_NINTH_VAL]);
	endproperty
	a_ninth: assert property (p_ninth) // see RULE7
		else $error("ninth bit not taken from its field");

	property p_tx_start;
		hold_wr && tx_go && tx_state == TX_IDLE && !hold_full
			##1 tx_go |=> tx_state == TX_SHIFT;
	endproperty
	a_tx_start: assert property (p_tx_start) // see RULE8
		else $error("write did not start transmission");

	property p_rx_copy;
		rx_accept |=> receive_done_flag
			&& receive_holding_reg == $past(next_rx_shift[7:0]);
	endproperty
	a_rx_copy: assert property (p_rx_copy) // see RULE12
		else $error("received word not copied");

	property p_err_clear;
		!continuous_receive_enable |=> !overrun;
	endproperty
	a_err_clear: assert property (p_err_clear) // see RULE16
		else $error("overrun survived receive disable");

	property p_rd_data;
		setup && !pwrite && paddr == `SSSP_OFS_RX_HOLD
			|=> prdata == {24'h000000, $past(receive_holding_reg)};
	endproperty
	a_rd_data: assert property (p_rd_data) // see RULE15
		else $error("receive holding read wrong");

endmodule

`default_nettype wire

// ### verif/sssp_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module sssp_master_model (
	output logic shift_strobe_pin,
	output logic data_pin_in,
	input wire logic data_pin_out,
	input wire logic data_pin_oe
);
	logic inv;

	initial begin
		inv = 1'b0;
		shift_strobe_pin = 1'b0;
		data_pin_in = 1'b1;
	end

	// Call only while reception is off: the pin flip looks like an edge
	task automatic set_pol(input logic p);
		inv = p;
		shift_strobe_pin = p;
	endtask

	// Drives a bit on each rise and samples on each fall, LSB first
	task automatic frame(input int n, input logic [8:0] tx,
		output logic [8:0] rx);
		rx = 9'h000;
		#1.7;
		for (int i = 0; i < n; i++) begin
			shift_strobe_pin = ~inv;
			data_pin_in = tx[i];
			#80;
			shift_strobe_pin = inv;
			rx[i] = data_pin_oe ? data_pin_out : 1'bx;
			#80;
		end
		// A released line must not keep showing the last bit
		data_pin_in = ~data_pin_in;
	endtask
endmodule

`default_nettype wire

// ### verif/sssp_port_tb_top.sv
`timescale 1ns/1ps
`include "sssp_defines.svh"
`default_nettype none

module sssp_port_tb_top;
	import sssp_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst, psel, penable, pwrite, cpu_sleep;
	sssp_addr_t paddr;
	sssp_word_t pwdata, prdata, a, b, x, d;
	logic pready, pslverr, strobe, din, dout, doe, irq, cpu_irq, wake_req;
	logic [8:0] rx;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 62567;
	int n;

	sssp_port sssp_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shift_strobe_pin(strobe), .data_pin_in(din),
		.data_pin_out(dout), .data_pin_oe(doe), .cpu_sleep(cpu_sleep),
		.irq(irq), .cpu_irq(cpu_irq), .wake_req(wake_req));

	sssp_master_model sssp_master_model_inst (.shift_strobe_pin(strobe),
		.data_pin_in(din), .data_pin_out(dout), .data_pin_oe(doe));

	always #2 ref_clk = ~ref_clk;

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(sssp_word_t got, sssp_word_t exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [8:0] exp_word(int n, sssp_word_t w, logic t);
		return (n == 9) ? {t, w[7:0]} : {1'b0, w[7:0]};
	endfunction

	task automatic apb(logic w, sssp_addr_t ad, sssp_word_t dt,
		output sssp_word_t q, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		// Only the bench timeout ends a wait for the slave's answer
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(sssp_addr_t ad, sssp_word_t dt);
		sssp_word_t q;
		logic e;
		apb(1'b1, ad, dt, q, e);
	endtask

	task automatic rd(sssp_addr_t ad, sssp_word_t exp, logic xe = 1'b0);
		sssp_word_t q;
		logic e;
		apb(1'b0, ad, 32'h00000000, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task automatic pins(logic [2:0] exp);
		@(negedge ref_clk);
		chk({29'h0, irq, cpu_irq, wake_req}, {29'h0, exp});
	endtask

	task automatic sleep(logic s);
		@(posedge ref_clk);
		cpu_sleep <= s;
	endtask

	initial begin
		{sys_rst, psel, penable, pwrite, cpu_sleep} = 5'h10;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`SSSP_OFS_FLAGS, 32'h00000001);
		rd(`SSSP_OFS_IRQ_STAT, 32'h00000000);
		rd(8'h30, 32'h00000000, 1'b1);
		wr(`SSSP_OFS_RX_CTL, 32'h00000080);
		wr(`SSSP_OFS_IRQ_EN, 32'h00000001);
		wr(`SSSP_OFS_INT_CTL, 32'h000000C0);
		for (int k = 0; k < 2; k++) begin
			a = $random(seed);
			b = $random(seed);
			x = $random(seed);
			n = 8 + k;
			wr(`SSSP_OFS_BAUD_CTL, k << 4);
			sssp_master_model_inst.set_pol(k[0]);
			wr(`SSSP_OFS_TX_CTL, 32'h30 | (k << 6) | x[0]);
			wr(`SSSP_OFS_TX_HOLD, a);
			wr(`SSSP_OFS_TX_HOLD, b);
			rd(`SSSP_OFS_FLAGS, 32'h00000000);
			wr(`SSSP_OFS_IRQ_CLR, 32'h00000007);
			sleep(1'b1);
			pins(3'b000);
			chk({31'h0, doe}, 32'h00000001);
			sssp_master_model_inst.frame(n, 9'h1FF, rx);
			chk(rx, exp_word(n, a, x[0]));
			pins(3'b111);
			rd(`SSSP_OFS_FLAGS, 32'h00000001);
			sssp_master_model_inst.frame(n, 9'h1FF, rx);
			chk(rx, exp_word(n, b, x[0]));
			sleep(1'b0);
			wr(`SSSP_OFS_IRQ_CLR, 32'h00000007);
		end
		wr(`SSSP_OFS_TX_CTL, 32'h00000010);
		wr(`SSSP_OFS_IRQ_EN, 32'h00000002);
		wr(`SSSP_OFS_RX_CTL, 32'h000000A0);
		sssp_master_model_inst.frame(8, 9'h0A5, rx);
		rd(`SSSP_OFS_FLAGS, 32'h00000001);
		// Internal clock source selected: the slave must stay deaf
		wr(`SSSP_OFS_TX_CTL, 32'h00000090);
		wr(`SSSP_OFS_RX_CTL, 32'h00000090);
		sssp_master_model_inst.frame(8, 9'h05A, rx);
		rd(`SSSP_OFS_FLAGS, 32'h00000001);
		wr(`SSSP_OFS_TX_CTL, 32'h00000010);
		wr(`SSSP_OFS_RX_CTL, 32'h000000D0);
		sleep(1'b1);
		d = $random(seed);
		sssp_master_model_inst.frame(9, d[8:0], rx);
		pins(3'b111);
		rd(`SSSP_OFS_FLAGS, 32'h00000003);
		rd(`SSSP_OFS_IRQ_STAT, 32'h00000002);
		rd(`SSSP_OFS_RX_CTL, 32'hD0 | d[8]);
		rd(`SSSP_OFS_RX_HOLD, d & 32'hFF);
		rd(`SSSP_OFS_FLAGS, 32'h00000001);
		wr(`SSSP_OFS_IRQ_CLR, 32'h00000007);
		pins(3'b000);
		chk({31'h0, doe}, 32'h00000000);
		d = $random(seed) | 32'h100;
		x = $random(seed) | 32'h100;
		sssp_master_model_inst.frame(9, d[8:0], rx);
		sssp_master_model_inst.frame(9, x[8:0], rx);
		wr(`SSSP_OFS_IRQ_EN, 32'h00000000);
		pins(3'b000);
		wr(`SSSP_OFS_IRQ_EN, 32'h00000007);
		rd(`SSSP_OFS_IRQ_STAT, 32'h00000006);
		rd(`SSSP_OFS_RX_CTL, 32'h000000D3);
		rd(`SSSP_OFS_RX_HOLD, d & 32'hFF);
		wr(`SSSP_OFS_RX_CTL, 32'h000000C0);
		rd(`SSSP_OFS_RX_CTL, 32'h000000C1);
		sleep(1'b0);
		complete_run();
	end
endmodule

`default_nettype wire
